/* core/tsm_cfg.svh */
// Register map, field positions and reset values of the I2C slave matcher
`ifndef TSM_CFG_SVH
`define TSM_CFG_SVH
`define TSM_IDX_STATUS 4'hB
`define TSM_IDX_OWN_ID 4'hC
`define TSM_IDX_SHIFT 4'hD
`define TSM_IDX_IGNORE 4'hE
`define TSM_IDX_CTRL 4'h8
`define TSM_IDX_IRQ_STAT 4'h9
`define TSM_IDX_IRQ_MASK 4'hA
`define TSM_RST_BYTE 8'h00
`define TSM_GCALL_BYTE 7'h00
`define TSM_ST_BYTE_DONE 7
`define TSM_ST_MATCH 6
`define TSM_ST_STRETCH 5
`define TSM_ST_DIR 1
`define TSM_ST_CAUSE 0
`define TSM_EV_ADDR 0
`define TSM_EV_STOP 1
`define TSM_EV_BYTE 2
`endif

/* core/tsm_pkg.sv */
// Types shared by the I2C slave matcher
`default_nettype none
package tsm_pkg;
   typedef enum logic [2:0] {
      TSM_IDLE = 3'b000,
      TSM_ADDR = 3'b001,
      TSM_ADDR_ACK = 3'b010,
      TSM_RX = 3'b011,
      TSM_TX = 3'b100,
      TSM_DATA_ACK = 3'b101,
      TSM_HOLD = 3'b110,
      TSM_SKIP = 3'b111
   } tsm_state_t;
endpackage
`default_nettype wire

/* core/tsm_slave.sv */
// I2C slave address match and shift-buffer access with APB registers
// Overview of operation
// - Cause bit: zero Stop, one address
// - Address match sets match-or-halt flag
// - Recognise 7-bit, 10-bit first byte, general call
// - Own id bits 7:1 address, bit 0 general call
// - 10-bit: match only 11110aa first byte
// - Shift buffer is the single shift register
// - Writes ignored while a byte shifts
// - Buffer access while held starts next operation
// - Mask mode: ignore bits force match
// - Dual mode: ignore field is second address
// - Address and Stop both raise shared flag
// - Stretch while address or data flag set
// - Buffer access or command clears flags
// - Capture direction bit of last matched address
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tsm_cfg.svh"
module tsm_slave
   import tsm_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [5:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe,
   output logic irq
);
   logic [2:0] scl_sync_reg, scl_sync_next;
   logic [2:0] sda_sync_reg, sda_sync_next;
   tsm_state_t state_reg, state_next;
   logic [7:0] own_station_id_reg, own_station_id_next;
   logic [7:0] shift_buffer_reg, shift_buffer_next;
   logic [7:0] ignore_or_second_id_reg, ignore_or_second_id_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic byte_done_flag_reg, byte_done_flag_next;
   logic match_or_halt_flag_reg, match_or_halt_flag_next;
   logic cause_select_status_reg, cause_select_status_next;
   logic dir_reg, dir_next;
   logic acknowledge_choice_reg, acknowledge_choice_next;
   logic rxack_reg, rxack_next;
   logic enable_reg, enable_next;
   logic sda_low_reg, sda_low_next;
   logic full_reg, full_next;
   logic scl_hold_reg, scl_hold_next;
   logic [2:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
   logic irq_reg, irq_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic scl_rise, scl_fall, start_det, stop_det, scl_s, sda_s;
   logic ev_addr, ev_stop, ev_byte;
   logic stretch, matched, gcall_hit, own_hit, second_hit;
   logic [3:0] widx;
   logic acc, wr, rd, buf_rd, buf_wr, cmd_wr;

   // Only the second and third stages are looked at
   assign scl_s = scl_sync_reg[1];
   assign sda_s = sda_sync_reg[1];
   assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
   assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
   assign start_det = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
   assign stop_det = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];

   // Address decode: received byte sits in shift buffer
   assign gcall_hit = own_station_id_reg[0] &&
      shift_buffer_reg[7:1] == `TSM_GCALL_BYTE && !shift_buffer_reg[0];
   assign own_hit = ((shift_buffer_reg[7:1] ^ own_station_id_reg[7:1]) &
      (ignore_or_second_id_reg[0] ? 7'h7F :
       ~ignore_or_second_id_reg[7:1])) == 7'h00;
   assign second_hit = ignore_or_second_id_reg[0] &&
      shift_buffer_reg[7:1] == ignore_or_second_id_reg[7:1];
   assign matched = own_hit | second_hit | gcall_hit;

   assign stretch = state_reg == TSM_HOLD;
   assign widx = paddr[5:2];
   assign acc = psel & penable & ~pready_reg;
   // Writes and read side effects land on the edge that ends the transfer
   assign wr = psel & penable & pready_reg & pwrite;
   assign rd = acc & ~pwrite;
   assign buf_rd = psel && penable && pready_reg && !pwrite &&
      widx == `TSM_IDX_SHIFT;
   assign buf_wr = wr && widx == `TSM_IDX_SHIFT;
   assign cmd_wr = wr && widx == `TSM_IDX_CTRL && pwdata[2];
   // Judged on the fall after the eighth bit, when the whole byte is in
   assign ev_addr = enable_reg && state_reg == TSM_ADDR && scl_fall &&
      full_reg && matched;
   assign ev_stop = stop_det && state_reg != TSM_IDLE
      && state_reg != TSM_SKIP;
   assign ev_byte = state_reg == TSM_DATA_ACK && scl_fall;

   always_comb
   begin
      scl_sync_next = {scl_sync_reg[1:0], scl_in};
      sda_sync_next = {sda_sync_reg[1:0], sda_in};
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_buffer_next = shift_buffer_reg;
      byte_done_flag_next = byte_done_flag_reg;
      match_or_halt_flag_next = match_or_halt_flag_reg;
      cause_select_status_next = cause_select_status_reg;
      dir_next = dir_reg;
      rxack_next = rxack_reg;
      sda_low_next = sda_low_reg;
      full_next = full_reg;
      if (!enable_reg)
      begin
         state_next = TSM_IDLE;
         sda_low_next = 1'b0;
         full_next = 1'b0;
      end
      else if (start_det)
      begin
         state_next = TSM_ADDR;
         bit_cnt_next = 3'h0;
         sda_low_next = 1'b0;
         full_next = 1'b0;
      end
      else if (stop_det)
      begin
         state_next = TSM_IDLE;
         sda_low_next = 1'b0;
         if (ev_stop)
         begin
            match_or_halt_flag_next = 1'b1;
            cause_select_status_next = 1'b0;
         end
      end
      else
      begin
         unique case (state_reg)
            TSM_IDLE, TSM_SKIP:
            begin
            end
            TSM_ADDR, TSM_RX:
               if (scl_rise)
               begin
                  shift_buffer_next = {shift_buffer_reg[6:0], sda_s};
                  bit_cnt_next = bit_cnt_reg + 3'h1;
                  full_next = bit_cnt_reg == 3'h7;
               end
               else if (scl_fall && full_reg)
               begin
                  // The fall that ends a Start is skipped: no bits yet
                  full_next = 1'b0;
                  if (state_reg == TSM_RX)
                  begin
                     state_next = TSM_DATA_ACK;
                     sda_low_next = ~acknowledge_choice_reg;
                  end
                  else
                     state_next = TSM_SKIP;
               end
            TSM_ADDR_ACK:
               if (scl_fall && acknowledge_choice_reg)
               begin
                  sda_low_next = 1'b0;
                  state_next = TSM_SKIP;
               end
               else if (scl_fall)
               begin
                  sda_low_next = dir_reg & ~shift_buffer_reg[7];
                  state_next = dir_reg ? TSM_TX : TSM_RX;
               end
            TSM_TX:
               if (scl_fall)
               begin
                  shift_buffer_next = {shift_buffer_reg[6:0], 1'b1};
                  bit_cnt_next = bit_cnt_reg + 3'h1;
                  sda_low_next = bit_cnt_reg != 3'h7 & ~shift_buffer_reg[6];
                  if (bit_cnt_reg == 3'h7)
                     state_next = TSM_DATA_ACK;
               end
            TSM_DATA_ACK:
               if (scl_rise && dir_reg)
                  rxack_next = sda_s;
               else if (scl_fall)
               begin
                  sda_low_next = 1'b0;
                  byte_done_flag_next = 1'b1;
                  state_next = TSM_HOLD;
               end
            TSM_HOLD:
               if (!match_or_halt_flag_reg && !byte_done_flag_reg)
               begin
                  if (dir_reg && !(byte_done_flag_reg || rxack_reg))
                  begin
                     state_next = TSM_TX;
                     sda_low_next = ~shift_buffer_reg[7];
                  end
                  else if (dir_reg && rxack_reg)
                     state_next = TSM_SKIP;
                  else
                     state_next = TSM_RX;
               end
         endcase
         if (ev_addr)
         begin
            match_or_halt_flag_next = 1'b1;
            cause_select_status_next = 1'b1;
            dir_next = shift_buffer_reg[0];
            // Ack is held back until software has answered
            state_next = TSM_HOLD;
         end
      end
      if (state_reg == TSM_HOLD && match_or_halt_flag_reg &&
          cause_select_status_reg && (buf_rd || buf_wr || cmd_wr))
      begin
         // Address ack released; byte transfer follows, or skip if acknowledge_choice_reg nacks
         state_next = TSM_ADDR_ACK;
         bit_cnt_next = 3'h0;
         sda_low_next = ~acknowledge_choice_reg;
      end
      if (buf_wr && stretch)
         shift_buffer_next = pwdata[7:0];
      if (buf_rd || buf_wr || cmd_wr)
      begin
         if (!ev_addr && !ev_stop)
            match_or_halt_flag_next = 1'b0;
         if (!ev_byte)
            byte_done_flag_next = 1'b0;
      end
      if (wr && widx == `TSM_IDX_STATUS)
      begin
         if (pwdata[`TSM_ST_BYTE_DONE] && !ev_byte)
            byte_done_flag_next = 1'b0;
         if (pwdata[`TSM_ST_MATCH] && !ev_addr && !ev_stop)
            match_or_halt_flag_next = 1'b0;
      end
      // One extra held cycle lets SDA settle before SCL is let go
      scl_hold_next = state_next == TSM_HOLD || stretch;
   end

   always_comb
   begin
      own_station_id_next = own_station_id_reg;
      ignore_or_second_id_next = ignore_or_second_id_reg;
      acknowledge_choice_next = acknowledge_choice_reg;
      enable_next = enable_reg;
      irq_mask_next = irq_mask_reg;
      irq_stat_next = irq_stat_reg | {ev_byte, ev_stop, ev_addr};
      prdata_next = 32'h0000_0000;
      pready_next = acc;
      pslverr_next = acc && pwrite &&
         (widx < `TSM_IDX_CTRL || widx > `TSM_IDX_IGNORE);
      if (wr)
      begin
         unique case (widx)
            `TSM_IDX_OWN_ID: own_station_id_next = pwdata[7:0];
            `TSM_IDX_IGNORE: ignore_or_second_id_next = pwdata[7:0];
            `TSM_IDX_CTRL:
            begin
               enable_next = pwdata[0];
               acknowledge_choice_next = pwdata[1];
            end
            `TSM_IDX_IRQ_MASK: irq_mask_next = pwdata[2:0];
            `TSM_IDX_IRQ_STAT:
               irq_stat_next = (irq_stat_reg & ~pwdata[2:0]) |
                  {ev_byte, ev_stop, ev_addr};
            `TSM_IDX_STATUS, `TSM_IDX_SHIFT: ;
            default: ;
         endcase
      end
      if (rd)
      begin
         unique case (widx)
            `TSM_IDX_STATUS:
               prdata_next[7:0] = {byte_done_flag_reg, match_or_halt_flag_reg,
                  stretch, rxack_reg, 2'b00, dir_reg, cause_select_status_reg};
            `TSM_IDX_OWN_ID: prdata_next[7:0] = own_station_id_reg;
            `TSM_IDX_SHIFT: prdata_next[7:0] = shift_buffer_reg;
            `TSM_IDX_IGNORE: prdata_next[7:0] = ignore_or_second_id_reg;
            `TSM_IDX_CTRL:
               prdata_next[1:0] = {acknowledge_choice_reg, enable_reg};
            `TSM_IDX_IRQ_STAT: prdata_next[2:0] = irq_stat_reg;
            `TSM_IDX_IRQ_MASK: prdata_next[2:0] = irq_mask_reg;
            default: pslverr_next = 1'b1;
         endcase
      end
      irq_next = |(irq_stat_next & irq_mask_next);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         state_reg <= TSM_IDLE;
         own_station_id_reg <= `TSM_RST_BYTE;
         shift_buffer_reg <= `TSM_RST_BYTE;
         ignore_or_second_id_reg <= `TSM_RST_BYTE;
         bit_cnt_reg <= 3'h0;
         byte_done_flag_reg <= 1'b0;
         match_or_halt_flag_reg <= 1'b0;
         cause_select_status_reg <= 1'b0;
         dir_reg <= 1'b0;
         acknowledge_choice_reg <= 1'b0;
         rxack_reg <= 1'b0;
         enable_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         full_reg <= 1'b0;
         scl_hold_reg <= 1'b0;
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         irq_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         scl_sync_reg <= scl_sync_next;
         sda_sync_reg <= sda_sync_next;
         state_reg <= state_next;
         own_station_id_reg <= own_station_id_next;
         shift_buffer_reg <= shift_buffer_next;
         ignore_or_second_id_reg <= ignore_or_second_id_next;
         bit_cnt_reg <= bit_cnt_next;
         byte_done_flag_reg <= byte_done_flag_next;
         match_or_halt_flag_reg <= match_or_halt_flag_next;
         cause_select_status_reg <= cause_select_status_next;
         dir_reg <= dir_next;
         acknowledge_choice_reg <= acknowledge_choice_next;
         rxack_reg <= rxack_next;
         enable_reg <= enable_next;
         sda_low_reg <= sda_low_next;
         full_reg <= full_next;
         scl_hold_reg <= scl_hold_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         irq_reg <= irq_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign scl_out = 1'b0;
   assign scl_oe = scl_hold_reg;
   assign sda_out = 1'b0;
   assign sda_oe = sda_low_reg;
   assign irq = irq_reg;

   a_addr_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
      ev_addr |=> match_or_halt_flag_reg && cause_select_status_reg)
      else $error("address match did not raise flag");
   a_stop_cause: assert property (@(posedge clock) disable iff (!rst_n)
      ev_stop |=> match_or_halt_flag_reg && !cause_select_status_reg)
      else $error("stop did not raise flag with cause zero");
   a_dir_capture: assert property (@(posedge clock) disable iff (!rst_n)
      ev_addr |=> dir_reg == $past(shift_buffer_reg[0]))
      else $error("direction not captured");
   a_write_blocked: assert property (@(posedge clock) disable iff (!rst_n)
      buf_wr && state_reg inside {TSM_RX, TSM_TX} && !scl_rise && !scl_fall
      && !start_det |=> shift_buffer_reg == $past(shift_buffer_reg))
      else $error("buffer written while shifting");
   a_stretch_hold: assert property (@(posedge clock) disable iff (!rst_n)
      ev_byte |=> ##1 scl_oe)
      else $error("clock not stretched after byte");
   a_access_clears: assert property (@(posedge clock) disable iff (!rst_n)
      buf_rd && !ev_addr && !ev_stop && !ev_byte
      |=> !match_or_halt_flag_reg && !byte_done_flag_reg)
      else $error("buffer access did not clear flags");
   a_access_resumes: assert property (@(posedge clock) disable iff (!rst_n)
      stretch && byte_done_flag_reg && buf_rd && !start_det && !stop_det
      && enable_reg |=> ##2 !scl_oe)
      else $error("access did not release clock");
   a_mask_match: assert property (@(posedge clock) disable iff (!rst_n)
      !ignore_or_second_id_reg[0] && ignore_or_second_id_reg[7:1] == 7'h7F
      |-> own_hit)
      else $error("fully masked address did not match");
   a_dual_match: assert property (@(posedge clock) disable iff (!rst_n)
      ignore_or_second_id_reg[0] &&
      shift_buffer_reg[7:1] == ignore_or_second_id_reg[7:1] |-> matched)
      else $error("second address did not match");
   a_gcall: assert property (@(posedge clock) disable iff (!rst_n)
      own_station_id_reg[0] && shift_buffer_reg == 8'h00 |-> matched)
      else $error("general call missed");
   c_addr: cover property (@(posedge clock) ev_addr);
   c_stop: cover property (@(posedge clock) ev_stop);
   c_byte: cover property (@(posedge clock) ev_byte && dir_reg);
   c_irq: cover property (@(posedge clock) irq);
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the I2C slave address matcher
`timescale 1ns/10ps
`default_nettype none
`include "tsm_cfg.svh"
module tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [5:0] paddr = 6'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq;
   logic m_scl, m_sda;
   wire scl_w;
   wire sda_w;
   int err_count = 0;
   int checked = 0;
   localparam logic [5:0] A_CTRL = {`TSM_IDX_CTRL, 2'b00};
   localparam logic [5:0] A_IRQS = {`TSM_IDX_IRQ_STAT, 2'b00};
   localparam logic [5:0] A_MASK = {`TSM_IDX_IRQ_MASK, 2'b00};
   localparam logic [5:0] A_STAT = {`TSM_IDX_STATUS, 2'b00};
   localparam logic [5:0] A_OWN = {`TSM_IDX_OWN_ID, 2'b00};
   localparam logic [5:0] A_SHIFT = {`TSM_IDX_SHIFT, 2'b00};
   localparam logic [5:0] A_IGN = {`TSM_IDX_IGNORE, 2'b00};
   // Pull-ups: a wire is high unless some party pulls it low
   assign scl_w = ~(m_scl | (scl_oe & ~scl_out));
   assign sda_w = ~(m_sda | (sda_oe & ~sda_out));
   always #2.5 clock = ~clock;
   tsm_slave u_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
      .sda_in(sda_w), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
   tsm_i2c_master u_mst (.scl_w(scl_w), .sda_w(sda_w), .scl_low(m_scl),
      .sda_low(m_sda));
   task automatic complete_run();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [5:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      chk("apb ready", 32'h1, {31'h0, pready});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] m,
      input logic [31:0] exp, input string nm);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, exp, r & m);
   endtask
   task automatic ck_irq(input logic exp);
      repeat (2) @(posedge clock);
      chk("irq level", {31'h0, exp}, {31'h0, irq});
   endtask
   // Software waits for the stretch before it touches the buffer
   task automatic wait_hold();
      int n;
      n = 0;
      while (scl_oe !== 1'b1 && n < 2000)
      begin
         @(posedge clock);
         n++;
      end
      chk("clock held", 32'h1, {31'h0, scl_oe});
   endtask
   // One address byte, then a Stop; hit says the slave must claim it
   task automatic txn(input logic [7:0] b, input logic hit, input logic nk);
      logic ack;
      wr(A_IRQS, 8'h07);
      u_mst.start();
      fork
         u_mst.send_byte(b, ack);
         if (hit)
         begin
            wait_hold();
            rdc(A_STAT, 32'hE3, {30'h18, b[0], 1'b1}, "addr status");
            chk("irq on match", 32'h1, {31'h0, irq});
            rdc(A_SHIFT, 32'hFF, {24'h0, b}, "shifted byte");
         end
      join
      chk("ack bit", {31'h0, nk | ~hit}, {31'h0, ack});
      rdc(A_STAT, 32'h60, 32'h0, "flags after access");
      u_mst.stop();
      if (hit & ~nk)
         rdc(A_STAT, 32'h41, 32'h40, "stop cause");
      wr(A_STAT, 8'hC0);
   endtask
   task automatic t_regs();
      logic [31:0] r;
      logic e;
      rdc(A_OWN, 32'hFFFFFFFF, 32'h0, "own id reset");
      rdc(A_SHIFT, 32'hFFFFFFFF, 32'h0, "shift reset");
      rdc(A_IGN, 32'hFFFFFFFF, 32'h0, "ignore reset");
      rdc(A_STAT, 32'hFFFFFFFF, 32'h0, "status reset");
      wr(A_OWN, 8'hA5);
      rdc(A_OWN, 32'hFFFFFFFF, 32'hA5, "own id write");
      apb(1'b0, 6'h3C, 32'h0, r, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      wr(A_CTRL, 8'h01);
      wr(A_MASK, 8'h01);
   endtask
   task automatic t_seven();
      wr(A_OWN, 8'hA4);
      wr(A_IGN, 8'h00);
      txn(8'hA4, 1'b1, 1'b0);
      // Idle slave is not stretching, so this write must be dropped
      // The Stop's clock pulse shifted one low bit in behind the address
      wr(A_SHIFT, 8'h5A);
      rdc(A_SHIFT, 32'hFF, 32'h48, "idle write dropped");
      txn(8'hA6, 1'b0, 1'b0);
   endtask
   // Write transfer with one data byte, stretched after each byte
   task automatic t_data();
      logic ack;
      u_mst.start();
      fork
         u_mst.send_byte(8'hA4, ack);
         begin
            wait_hold();
            rdc(A_SHIFT, 32'hFF, 32'hA4, "address byte");
         end
      join
      fork
         begin
            u_mst.send_byte(8'h3C, ack);
            u_mst.stop();
         end
         begin
            wait_hold();
            rdc(A_STAT, 32'hE0, 32'hA0, "byte status");
            rdc(A_SHIFT, 32'hFF, 32'h3C, "received byte");
         end
      join
      chk("data ack", 32'h0, {31'h0, ack});
      rdc(A_STAT, 32'hE3, 32'h40, "data stop status");
      wr(A_STAT, 8'hC0);
   endtask
   task automatic t_mask();
      wr(A_IGN, 8'h02);
      txn(8'hA6, 1'b1, 1'b0);
      wr(A_IGN, 8'h04);
      txn(8'hA6, 1'b0, 1'b0);
      txn(8'hA0, 1'b1, 1'b0);
   endtask
   task automatic t_dual();
      wr(A_IGN, 8'h63);
      txn(8'h62, 1'b1, 1'b0);
      txn(8'hA4, 1'b1, 1'b0);
      txn(8'h84, 1'b0, 1'b0);
   endtask
   task automatic t_gcall();
      wr(A_IGN, 8'h00);
      txn(8'h00, 1'b0, 1'b0);
      wr(A_OWN, 8'hA5);
      txn(8'h00, 1'b1, 1'b0);
      txn(8'h01, 1'b0, 1'b0);
   endtask
   task automatic t_tenbit();
      wr(A_OWN, 8'hF4);
      txn(8'hF4, 1'b1, 1'b0);
      txn(8'hF6, 1'b0, 1'b0);
      wr(A_CTRL, 8'h03);
      txn(8'hF5, 1'b1, 1'b1);
      wr(A_CTRL, 8'h01);
   endtask
   task automatic t_irq();
      wr(A_OWN, 8'hA4);
      wr(A_IRQS, 8'h07);
      txn(8'hA4, 1'b1, 1'b0);
      rdc(A_IRQS, 32'hFF, 32'h03, "event bits");
      wr(A_MASK, 8'h00);
      ck_irq(1'b0);
      wr(A_MASK, 8'h02);
      ck_irq(1'b1);
      wr(A_IRQS, 8'h02);
      ck_irq(1'b0);
      rdc(A_IRQS, 32'hFF, 32'h01, "event after clear");
      wr(A_IRQS, 8'h01);
      rdc(A_IRQS, 32'hFF, 32'h00, "events cleared");
      wr(A_MASK, 8'h01);
   endtask
   initial
   begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_seven();
      t_data();
      t_mask();
      t_dual();
      t_gcall();
      t_tenbit();
      t_irq();
      complete_run();
   end
   // About twenty byte frames fit many times over in this span
   initial
   begin
      #200000;
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire

/* dv/tsm_i2c_master.sv */
// Behavioural I2C bus master that drives the slave over open-drain wires
`timescale 1ns/10ps
`default_nettype none
module tsm_i2c_master
(
   input wire logic scl_w,
   input wire logic sda_w,
   output logic scl_low,
   output logic sda_low
);
   // Quarter of the 64 ns link clock period
   localparam realtime Q = 16.0;
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Release SCL, then wait while a stretching slave keeps it low
   task automatic clk_high();
      scl_low = 1'b0;
      wait (scl_w === 1'b1);
   endtask
   task automatic start();
      sda_low = 1'b1;
      #(2 * Q);
      scl_low = 1'b1;
      #(2 * Q);
   endtask
   // SDA only moves while SCL is low, so no false Start or Stop
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         sda_low = ~b[i];
         #Q;
         clk_high();
         #(2 * Q);
         scl_low = 1'b1;
         #Q;
      end
      sda_low = 1'b0;
      #Q;
      clk_high();
      #Q;
      ack = sda_w;
      #Q;
      scl_low = 1'b1;
      #Q;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #Q;
      clk_high();
      #(2 * Q);
      sda_low = 1'b0;
      #(4 * Q);
   endtask
endmodule
`default_nettype wire
